// File: core/cfl_pkg.sv
// Package with constants for the configuration loader and bus cycle block
package cfl_pkg;
  // IO address of the external configuration latch
  localparam logic [15:0] CFG_IO_ADDR = 16'h8410;
  // Configuration word field positions
  localparam int CFG_PAGE_LO = 0;
  localparam int CFG_PROT_LO = 1;
  localparam int CFG_CONSOLE = 2;
  localparam int CFG_PAGE_MID = 3;
  localparam int CFG_IRQ_LEVEL = 4;
  localparam int CFG_PAGE_HI = 5;
  localparam int CFG_PARITY_ODD = 6;
  localparam int CFG_SELF_TEST = 7;
  localparam int CFG_ROM_PRESENT = 8;
  localparam int CFG_DMA_PRESENT = 9;
  localparam int CFG_BASIC_MODE = 10;
  localparam int CFG_EXPANSION = 11;
  localparam int CFG_PROT_MID = 12;
  localparam int CFG_PROT_HI = 13;
  // Reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Fault register bit for a self-test failure
  localparam int FAULT_SELF_TEST = 13;
  // Pending interrupt level raised by any fault
  localparam int PEND_MACHINE_ERR = 1;
  // Failure bit positions in general register zero
  localparam int FAIL_BIT_LO = 7;
  localparam int FAIL_BIT_HI = 15;
  // Least length of a machine cycle in clock periods
  localparam logic [3:0] CYCLE_MIN_CLKS = 4'h2;
  // Cycle sequencer states
  typedef enum logic [5:0] {
    CFL_ST_IDLE = 6'h01,
    CFL_ST_EXT1 = 6'h02,
    CFL_ST_EXT2 = 6'h04,
    CFL_ST_INT1 = 6'h08,
    CFL_ST_INT2 = 6'h10,
    CFL_ST_WAIT = 6'h20
  } cfl_state_e;
  // Requested cycle types
  localparam logic [2:0] CYC_INTERNAL = 3'h0;
  localparam logic [2:0] CYC_FETCH = 3'h1;
  localparam logic [2:0] CYC_OP_READ = 3'h2;
  localparam logic [2:0] CYC_OP_WRITE = 3'h3;
  localparam logic [2:0] CYC_IO_READ = 3'h4;
  localparam logic [2:0] CYC_IO_WRITE = 3'h5;
endpackage : cfl_pkg

// File: core/cfl_core.sv
// Configuration load, self-test reporting and machine cycle signalling
`timescale 1ns/1ps

// Function
// - Latch output enable low on config read
// - Bit4 interrupt sensitivity, bit2 console enable
// - Bit6 parity sense, bit7 power-up self-test
// - Bit10 selects basic or extended mode
// - Bit8 start-up ROM, bit9 DMA present
// - Bit11 expansion; bits 14-15 reserved
// - Copy latch on init and no-op/breakpoint
// - Software config read leaves internal copy
// - Page bank code decoded to bank count
// - Pass output high when tests pass/skipped
// - Failure sets R0 bit, fault bit 13
// - R0 failure bit per failed routine, 7-15
// - Fault sets level 1 pending bit only
// - Clear captured interrupts/faults before execution
// - Internal cycles two clocks; external extendable
// - Requests accepted only at cycle end
// - Strobes only in external cycles
// - IO cycles: operand line high, memory/IO low
// - Branch refills pipeline with two fetches
// - Memory/IO select low for IO space
// - Internal IO commands handled; others validated
// - Init reads config word with enable low
module cfl_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Cycle requests from the sequencer
  input wire logic cyc_req_i,
  input wire logic [2:0] cyc_type_i,
  input wire logic [15:0] cyc_addr_i,
  input wire logic cmd_internal_i,
  input wire logic cmd_legal_i,
  input wire logic noop_breakpoint_instr_i,
  input wire logic branch_taken_i,
  input wire logic init_done_i,
  input wire logic [8:0] self_test_fail_i,
  input wire logic irq_pending_i,
  // Bus pins
  input wire logic ready_pin_i,
  input wire logic [15:0] data_pin_i,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic data_strobe_n_o,
  output logic address_strobe_o,
  output logic operand_line_o,
  output logic memory_io_line_o,
  output logic transfer_direction_o,
  output logic config_output_enable_n_o,
  output logic [15:0] addr_pin_o,
  // Results
  output logic cyc_done_o,
  output logic [15:0] io_rdata_o,
  output logic io_illegal_o,
  output logic irq_accept_o,
  output logic refill_fetch_o,
  output logic [15:0] system_configuration_word_o,
  output logic [4:0] page_bank_count_o,
  output logic self_test_pass_out_o,
  output logic [15:0] general_reg_zero_o,
  output logic [15:0] fault_register_o,
  output logic [15:0] pending_irq_register_o
);

  // Synchronised pins
  logic rdy_s1_reg, rdy_s2_reg;
  logic [15:0] dat_s1_reg, dat_s2_reg;
  // Cycle sequencing state
  cfl_pkg::cfl_state_e st_reg, st_next;
  logic [2:0] typ_reg, typ_next;
  logic [15:0] adr_reg, adr_next;
  logic cfg_rd_reg, cfg_rd_next;
  logic boot_reg, boot_next;
  logic [1:0] refill_reg, refill_next;
  // Output registers
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, ds_n_reg, ds_n_next, as_reg, as_next;
  logic op_reg, op_next, mio_reg, mio_next, dir_reg, dir_next, oe_n_reg, oe_n_next;
  logic done_reg, done_next, ill_reg, ill_next, acc_reg, acc_next;
  logic [15:0] rdata_reg, rdata_next;
  // Configuration and test state
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] latch_reg, latch_next;
  logic load_pend_reg, load_pend_next;
  logic [4:0] banks_reg, banks_next;
  logic pass_reg, pass_next;
  logic [15:0] r0_reg, r0_next, ft_reg, ft_next, pi_reg, pi_next;
  logic is_io, is_ext, is_cfg;
  logic fetch_flag_reg; // Refill pending, registered so the pin comes from a flop

  // Two flops for the asynchronous pin inputs
  always_ff @(posedge clk_i) begin
    rdy_s1_reg <= ready_pin_i;
    rdy_s2_reg <= rdy_s1_reg;
    dat_s1_reg <= data_pin_i;
    dat_s2_reg <= dat_s1_reg;
  end

  // Decode of the requested cycle
  always_comb begin
    is_io = (cyc_type_i == cfl_pkg::CYC_IO_READ) || (cyc_type_i == cfl_pkg::CYC_IO_WRITE);
    is_cfg = (cyc_type_i == cfl_pkg::CYC_IO_READ) && (cyc_addr_i == cfl_pkg::CFG_IO_ADDR);
    // Internally decoded IO other than the latch read is not put on the bus
    is_ext = (cyc_type_i != cfl_pkg::CYC_INTERNAL) && !(is_io && cmd_internal_i && !is_cfg);
  end

  // Cycle sequencer next state
  always_comb begin
    st_next = st_reg;
    typ_next = typ_reg;
    adr_next = adr_reg;
    cfg_rd_next = cfg_rd_reg;
    boot_next = boot_reg;
    refill_next = refill_reg;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    ds_n_next = 1'b1;
    as_next = 1'b0;
    op_next = op_reg;
    mio_next = mio_reg;
    dir_next = dir_reg;
    oe_n_next = 1'b1;
    done_next = 1'b0;
    ill_next = 1'b0;
    acc_next = 1'b0;
    rdata_next = rdata_reg;
    if (branch_taken_i) begin
      refill_next = 2'h2;
    end
    unique case (st_reg)
      cfl_pkg::CFL_ST_IDLE: begin
        if (boot_reg) begin
          // First action after reset: fetch the configuration word
          boot_next = 1'b0;
          typ_next = cfl_pkg::CYC_IO_READ;
          adr_next = cfl_pkg::CFG_IO_ADDR;
          cfg_rd_next = 1'b1;
          op_next = 1'b1;
          mio_next = 1'b0;
          dir_next = 1'b1;
          as_next = 1'b1;
          st_next = cfl_pkg::CFL_ST_EXT1;
        end else if (refill_reg != 2'h0) begin
          // Two back-to-back fetches from the new location
          typ_next = cfl_pkg::CYC_FETCH;
          refill_next = refill_reg - 2'h1;
          op_next = 1'b0;
          mio_next = 1'b1;
          dir_next = 1'b1;
          as_next = 1'b1;
          st_next = cfl_pkg::CFL_ST_EXT1;
        end else if (cyc_req_i) begin
          typ_next = cyc_type_i;
          adr_next = cyc_addr_i;
          cfg_rd_next = is_cfg;
          if (is_io && !cmd_internal_i && !cmd_legal_i) begin
            // Illegal command never reaches the bus
            ill_next = 1'b1;
            done_next = 1'b1;
          end else if (is_ext) begin
            op_next = (cyc_type_i != cfl_pkg::CYC_FETCH);
            mio_next = !is_io;
            dir_next = (cyc_type_i != cfl_pkg::CYC_OP_WRITE)
                       && (cyc_type_i != cfl_pkg::CYC_IO_WRITE);
            as_next = 1'b1;
            st_next = cfl_pkg::CFL_ST_EXT1;
          end else begin
            // Internal cycle: no strobes, fixed two clocks
            op_next = 1'b0;
            mio_next = 1'b1;
            dir_next = 1'b1;
            st_next = cfl_pkg::CFL_ST_INT1;
          end
        end
      end
      cfl_pkg::CFL_ST_EXT1: begin
        // Data phase strobes; latch enable follows the read strobe
        rd_n_next = !dir_reg;
        wr_n_next = dir_reg;
        ds_n_next = 1'b0;
        oe_n_next = !cfg_rd_reg;
        st_next = cfl_pkg::CFL_ST_EXT2;
      end
      cfl_pkg::CFL_ST_EXT2: begin
        if (rdy_s2_reg) begin
          rdata_next = dat_s2_reg;
          done_next = 1'b1;
          acc_next = irq_pending_i;
          st_next = cfl_pkg::CFL_ST_IDLE;
        end else begin
          // Wait states stretch the cycle
          rd_n_next = !dir_reg;
          wr_n_next = dir_reg;
          ds_n_next = 1'b0;
          oe_n_next = !cfg_rd_reg;
          st_next = cfl_pkg::CFL_ST_WAIT;
        end
      end
      cfl_pkg::CFL_ST_WAIT: begin
        rd_n_next = !dir_reg;
        wr_n_next = dir_reg;
        ds_n_next = 1'b0;
        oe_n_next = !cfg_rd_reg;
        st_next = cfl_pkg::CFL_ST_EXT2;
      end
      cfl_pkg::CFL_ST_INT1: begin
        st_next = cfl_pkg::CFL_ST_INT2;
      end
      cfl_pkg::CFL_ST_INT2: begin
        done_next = 1'b1;
        acc_next = irq_pending_i;
        st_next = cfl_pkg::CFL_ST_IDLE;
      end
      default: begin
        st_next = cfl_pkg::CFL_ST_IDLE;
      end
    endcase
  end

  // Cycle sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= cfl_pkg::CFL_ST_IDLE;
      typ_reg <= cfl_pkg::CYC_INTERNAL;
      adr_reg <= 16'h0000;
      cfg_rd_reg <= 1'b0;
      boot_reg <= 1'b1;
      refill_reg <= 2'h0;
      fetch_flag_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      ds_n_reg <= 1'b1;
      as_reg <= 1'b0;
      op_reg <= 1'b0;
      mio_reg <= 1'b1;
      dir_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
      acc_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      typ_reg <= typ_next;
      adr_reg <= adr_next;
      cfg_rd_reg <= cfg_rd_next;
      boot_reg <= boot_next;
      refill_reg <= refill_next;
      fetch_flag_reg <= (refill_next != 2'h0);
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      ds_n_reg <= ds_n_next;
      as_reg <= as_next;
      op_reg <= op_next;
      mio_reg <= mio_next;
      dir_reg <= dir_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
      acc_reg <= acc_next;
      rdata_reg <= rdata_next;
    end
  end

  // Configuration copy, bank decode and self-test results
  always_comb begin
    latch_next = latch_reg;
    cfg_next = cfg_reg;
    load_pend_next = load_pend_reg;
    r0_next = r0_reg;
    ft_next = ft_reg;
    pi_next = pi_reg;
    pass_next = pass_reg;
    if (noop_breakpoint_instr_i) begin
      load_pend_next = 1'b1;
    end
    if (st_reg == cfl_pkg::CFL_ST_EXT2 && rdy_s2_reg && cfg_rd_reg) begin
      // Software reads only return the word; only boot/no-op update the copy
      latch_next = dat_s2_reg;
      if (load_pend_reg) begin
        cfg_next = dat_s2_reg;
        load_pend_next = noop_breakpoint_instr_i;
      end
    end
    unique case ({cfg_reg[cfl_pkg::CFG_PAGE_HI], cfg_reg[cfl_pkg::CFG_PAGE_MID],
                  cfg_reg[cfl_pkg::CFG_PAGE_LO]})
      3'h0: banks_next = 5'h00;
      3'h1: banks_next = 5'h01;
      3'h2: banks_next = 5'h02;
      3'h3: banks_next = 5'h04;
      3'h4: banks_next = 5'h08;
      default: banks_next = 5'h10;
    endcase
    if (init_done_i) begin
      // Self-test skipped or clean counts as a pass
      if (!cfg_reg[cfl_pkg::CFG_SELF_TEST] || self_test_fail_i == 9'h000) begin
        pass_next = 1'b1;
      end else begin
        r0_next[cfl_pkg::FAIL_BIT_HI:cfl_pkg::FAIL_BIT_LO] = self_test_fail_i;
        ft_next = 16'h0000;
        ft_next[cfl_pkg::FAULT_SELF_TEST] = 1'b1;
        pass_next = 1'b0;
      end
      // Events caught during the test are discarded; only the test fault survives
      pi_next = 16'h0000;
      pi_next[cfl_pkg::PEND_MACHINE_ERR] = (ft_next != 16'h0000);
    end
  end

  // Configuration and test registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= cfl_pkg::CFG_RESET;
      cfg_reg <= cfl_pkg::CFG_RESET;
      load_pend_reg <= 1'b1;
      banks_reg <= 5'h00;
      r0_reg <= 16'h0000;
      ft_reg <= 16'h0000;
      pi_reg <= 16'h0000;
      pass_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      cfg_reg <= cfg_next;
      load_pend_reg <= load_pend_next;
      banks_reg <= banks_next;
      r0_reg <= r0_next;
      ft_reg <= ft_next;
      pi_reg <= pi_next;
      pass_reg <= pass_next;
    end
  end

  // Output wiring, all from flops
  assign read_strobe_n_o = rd_n_reg;
  assign write_strobe_n_o = wr_n_reg;
  assign data_strobe_n_o = ds_n_reg;
  assign address_strobe_o = as_reg;
  assign operand_line_o = op_reg;
  assign memory_io_line_o = mio_reg;
  assign transfer_direction_o = dir_reg;
  assign config_output_enable_n_o = oe_n_reg;
  assign addr_pin_o = adr_reg;
  assign cyc_done_o = done_reg;
  assign io_rdata_o = rdata_reg;
  assign io_illegal_o = ill_reg;
  assign irq_accept_o = acc_reg;
  assign refill_fetch_o = fetch_flag_reg;
  assign system_configuration_word_o = cfg_reg;
  assign page_bank_count_o = banks_reg;
  assign self_test_pass_out_o = pass_reg;
  assign general_reg_zero_o = r0_reg;
  assign fault_register_o = ft_reg;
  assign pending_irq_register_o = pi_reg;

  // Checks
  chk_oe_only_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    !config_output_enable_n_o |-> cfg_rd_reg && !read_strobe_n_o)
    else $error("latch enable outside config read");
  chk_no_int_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == cfl_pkg::CFL_ST_INT2) |-> read_strobe_n_o && write_strobe_n_o && data_strobe_n_o)
    else $error("strobe in internal cycle");
  chk_int_two_clk: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == cfl_pkg::CFL_ST_INT1) |=> (st_reg == cfl_pkg::CFL_ST_INT2) ##1 cyc_done_o)
    else $error("internal cycle not two clocks");
  chk_io_lines: assert property (@(posedge clk_i) disable iff (rst_i)
    !data_strobe_n_o && !memory_io_line_o |-> operand_line_o)
    else $error("IO cycle operand line low");
  chk_accept_end: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_accept_o |-> cyc_done_o) else $error("request taken mid cycle");
  chk_pass_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    self_test_pass_out_o |-> !fault_register_o[cfl_pkg::FAULT_SELF_TEST])
    else $error("pass with fault");
  chk_pend_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fault_register_o[cfl_pkg::FAULT_SELF_TEST]) |-> pending_irq_register_o[1])
    else $error("fault without pending");
  chk_cfg_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !load_pend_reg |=> $stable(system_configuration_word_o))
    else $error("config copy changed");
endmodule : cfl_core

// File: bench/cfl_latch_model.sv
// Model of the external configuration latch and the bus ready logic
`timescale 1ns/1ps
module cfl_latch_model (
  // Clock
  input wire logic clk_i,
  // Bus controls from the block
  input wire logic config_output_enable_n_i,
  input wire logic data_strobe_n_i,
  // Settings from the bench
  input wire logic [15:0] latch_word_i,
  input wire logic [3:0] wait_clks_i,
  // Answers to the block
  output logic [15:0] data_pin_o,
  output logic ready_pin_o
);
  logic [15:0] last_word = 16'h0000; // Value last driven by the latch
  logic [3:0] wait_cnt = 4'h0; // Clocks spent in the current strobe
  // Remember the driven word and count wait states while strobed
  always @(posedge clk_i) begin
    if (!config_output_enable_n_i) begin
      last_word <= latch_word_i;
    end
    wait_cnt <= data_strobe_n_i ? 4'h0 : wait_cnt + 4'h1;
  end
  // Released bus shows the inverse, so a stale read never looks right
  assign data_pin_o = config_output_enable_n_i ? ~last_word : latch_word_i;
  // Ready only after the chosen number of wait states
  assign ready_pin_o = !data_strobe_n_i && (wait_cnt >= wait_clks_i);
endmodule : cfl_latch_model

// File: bench/test_config_load_self_test_bus_cycles.sv
// Self-checking bench for the configuration loader and bus cycle block
`timescale 1ns/1ps
module test_config_load_self_test_bus_cycles;
  // Design inputs
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_req_i = 1'b0;
  logic [2:0] cyc_type_i = 3'h0;
  logic [15:0] cyc_addr_i = 16'h0000;
  logic cmd_internal_i = 1'b0;
  logic cmd_legal_i = 1'b1;
  logic noop_i = 1'b0;
  logic branch_i = 1'b0;
  logic init_done_i = 1'b0;
  logic [8:0] fail_i = 9'h000;
  logic irq_i = 1'b0;
  logic ready_w;
  logic [15:0] data_w;
  // Design outputs
  logic rd_n, wr_n, ds_n, as_o, op_o, mio_o, dir_o, oe_n, done_o, ill_o, acc_o, refill_o, pass_o;
  logic [15:0] addr_o, rdata_o, cfg_o, r0_o, ft_o, pi_o;
  logic [4:0] banks_o;
  // Partner settings
  logic [15:0] latch_word = 16'h0E95;
  logic [3:0] wait_clks = 4'h0;
  // Scoreboard and bus monitor counts
  int fails = 0;
  int comparisons = 0;
  int ticks = 0;
  int strobes = 0;
  int oe_lows = 0;
  int as_rises = 0;
  int accepts = 0;
  int n_cyc, n_strb, n_oe, n0, a0;
  logic got_ill;
  logic as_last = 1'b0;
  logic [2:0] lines = 3'h0; // Direction, operand, memory/io at last strobe
  logic [4:0] banks [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h10};
  logic [2:0] lines_exp [6] = '{3'h0, 3'h5, 3'h7, 3'h3, 3'h6, 3'h2};

  cfl_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_req_i(cyc_req_i), .cyc_type_i(cyc_type_i),
    .cyc_addr_i(cyc_addr_i), .cmd_internal_i(cmd_internal_i), .cmd_legal_i(cmd_legal_i),
    .noop_breakpoint_instr_i(noop_i), .branch_taken_i(branch_i), .init_done_i(init_done_i),
    .self_test_fail_i(fail_i), .irq_pending_i(irq_i), .ready_pin_i(ready_w), .data_pin_i(data_w),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .data_strobe_n_o(ds_n),
    .address_strobe_o(as_o), .operand_line_o(op_o), .memory_io_line_o(mio_o),
    .transfer_direction_o(dir_o), .config_output_enable_n_o(oe_n), .addr_pin_o(addr_o),
    .cyc_done_o(done_o), .io_rdata_o(rdata_o), .io_illegal_o(ill_o), .irq_accept_o(acc_o),
    .refill_fetch_o(refill_o), .system_configuration_word_o(cfg_o), .page_bank_count_o(banks_o),
    .self_test_pass_out_o(pass_o), .general_reg_zero_o(r0_o), .fault_register_o(ft_o),
    .pending_irq_register_o(pi_o));
  cfl_latch_model i_latch (.clk_i(clk_i), .config_output_enable_n_i(oe_n),
    .data_strobe_n_i(ds_n), .latch_word_i(latch_word), .wait_clks_i(wait_clks),
    .data_pin_o(data_w), .ready_pin_o(ready_w));

  // Clock at 20 MHz
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Bus monitor and hang guard
  always @(posedge clk_i) begin
    if (!ds_n || !rd_n || !wr_n) begin
      strobes++;
      lines = {dir_o, op_o, mio_o};
    end
    if (!oe_n) oe_lows++;
    if (as_o && !as_last) as_rises++;
    as_last = as_o;
    if (acc_o) accepts++;
    ticks++;
    if (ticks == 6000) begin
      fails++;
      final_report();
    end
  end

  // One comparison, case equality so unknowns fail
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // One machine cycle request held until done, with bus activity counted
  task automatic cyc(input logic [2:0] kind, input logic [15:0] addr, input logic intl,
                     input logic legal);
    int s0, o0;
    @(posedge clk_i);
    cyc_req_i <= 1'b1;
    cyc_type_i <= kind;
    cyc_addr_i <= addr;
    cmd_internal_i <= intl;
    cmd_legal_i <= legal;
    s0 = strobes;
    o0 = oe_lows;
    n_cyc = 0;
    got_ill = 1'b0;
    // Look just after each edge so the request drops before the block could take it again
    do begin
      @(posedge clk_i);
      #1;
      n_cyc++;
      got_ill |= ill_o;
    end while (done_o !== 1'b1 && n_cyc < 60);
    cyc_req_i <= 1'b0;
    #1;
    n_strb = strobes - s0;
    n_oe = oe_lows - o0;
    cmp("cycle done", 16'h0001, {15'h0, done_o});
  endtask : cyc

  // Reset, then let the boot read of the latch finish
  task automatic boot(input logic [15:0] word);
    int k;
    latch_word <= word;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (done_o !== 1'b1 && k < 60);
  endtask : boot

  // Self-test outcome after init completes
  task automatic selftest(input logic [15:0] word, input logic [8:0] fv, input logic [15:0] r0,
                          input logic pass);
    boot(word);
    fail_i <= fv;
    init_done_i <= 1'b1;
    @(posedge clk_i);
    init_done_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp("pass out", {15'h0, pass}, {15'h0, pass_o});
    cmp("reg zero", r0, r0_o);
    cmp("fault bit", {15'h0, !pass}, {15'h0, ft_o[13]});
    cmp("pending", pass ? 16'h0000 : 16'h0002, pi_o);
  endtask : selftest

  // Counts and verdict
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    boot(16'h0E95);
    cmp("boot enable", 16'h0001, {15'h0, oe_lows > 0});
    cmp("config word", 16'h0E95, cfg_o & 16'h3FFF);
    $display("test boot done");
    // Plain software read must not touch the internal copy
    latch_word <= 16'h1234;
    cyc(cfl_pkg::CYC_IO_READ, cfl_pkg::CFG_IO_ADDR, 1'b0, 1'b1);
    cmp("latch read", 16'h1234, rdata_o);
    cmp("config kept", 16'h0E95, cfg_o & 16'h3FFF);
    cmp("read enable", 16'h0001, {15'h0, n_oe > 0});
    $display("test software read done");
    // Every page bank code, reloaded through a no-op
    for (int c = 0; c < 8; c++) begin
      latch_word <= {10'h0, c[2], 1'b0, c[1], 2'h0, c[0]};
      noop_i <= 1'b1;
      @(posedge clk_i);
      noop_i <= 1'b0;
      cyc(cfl_pkg::CYC_IO_READ, cfl_pkg::CFG_IO_ADDR, 1'b0, 1'b1);
      // The bank count follows the copied word by one clock
      @(posedge clk_i);
      #1;
      cmp("bank count", {11'h0, banks[c]}, {11'h0, banks_o});
    end
    $display("test bank codes done");
    // Line states of each external cycle kind
    for (int t = 1; t < 6; t++) begin
      cyc(t[2:0], 16'h0100, 1'b0, 1'b1);
      cmp("cycle lines", {13'h0, lines_exp[t]}, {13'h0, lines});
      cmp("ext strobes", 16'h0001, {15'h0, n_strb > 0});
    end
    $display("test cycle kinds done");
    // Internal cycle with a pending request, internal and illegal IO
    irq_i <= 1'b1;
    a0 = accepts;
    cyc(cfl_pkg::CYC_INTERNAL, 16'h0000, 1'b0, 1'b1);
    irq_i <= 1'b0;
    cmp("internal length", 16'h0003, n_cyc[15:0]);
    cmp("internal strobes", 16'h0000, n_strb[15:0]);
    cmp("irq accepted", 16'h0001, {15'h0, acc_o});
    cyc(cfl_pkg::CYC_IO_READ, 16'h4000, 1'b1, 1'b1);
    cmp("internal io strobes", 16'h0000, n_strb[15:0]);
    cyc(cfl_pkg::CYC_IO_WRITE, 16'h4001, 1'b0, 1'b0);
    cmp("illegal flag", 16'h0001, {15'h0, got_ill});
    cmp("illegal strobes", 16'h0000, n_strb[15:0]);
    $display("test internal cycles done");
    // Wait states stretch an external cycle
    cyc(cfl_pkg::CYC_IO_READ, 16'h0200, 1'b0, 1'b1);
    n0 = n_cyc;
    wait_clks <= 4'h3;
    cyc(cfl_pkg::CYC_IO_READ, 16'h0200, 1'b0, 1'b1);
    wait_clks <= 4'h0;
    cmp("wait stretch", 16'h0001, {15'h0, n_cyc >= n0 + 3});
    $display("test wait states done");
    // Taken branch refills with two fetches
    a0 = as_rises;
    branch_i <= 1'b1;
    @(posedge clk_i);
    branch_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    cmp("refill fetches", 16'h0002, 16'(as_rises - a0));
    cmp("refill lines", 16'h0005, {13'h0, lines});
    $display("test branch refill done");
    // Self-test pass, skipped, and each failing routine
    irq_i <= 1'b1;
    selftest(16'h0080, 9'h000, 16'h0000, 1'b1);
    irq_i <= 1'b0;
    selftest(16'h0000, 9'h001, 16'h0000, 1'b1);
    for (int i = 0; i < 9; i++) begin
      selftest(16'h0080, 9'(1 << i), 16'(1 << (i + 7)), 1'b0);
    end
    $display("test self test done");
    final_report();
  end
endmodule : test_config_load_self_test_bus_cycles
